// ---- hdl/oag_defines.svh ----
`ifndef OAG_DEFINES_SVH
`define OAG_DEFINES_SVH

// ---------------------------------------------------------------
// address widths
// ---------------------------------------------------------------
`define OAG_NEAR_BITS 13
`define OAG_NEAR_BYTES 8192
`define OAG_REG_BITS 4

// ---------------------------------------------------------------
// fixed register numbers
// ---------------------------------------------------------------
`define OAG_DEFAULT_WORK_REG 4'h0
`define OAG_MAC_X_LO 4'h8
`define OAG_MAC_X_HI 4'h9
`define OAG_MAC_Y_LO 4'ha
`define OAG_MAC_Y_HI 4'hb
`define OAG_MAC_X_INDEX 4'h9
`define OAG_MAC_Y_INDEX 4'hb

// ---------------------------------------------------------------
// mode masks per instruction class (bit positions follow mode codes)
// ---------------------------------------------------------------
`define OAG_MASK_FILE 8'h80
`define OAG_MASK_MCU 8'h4f
`define OAG_MASK_MOVE 8'hff
`define OAG_MASK_ACC 8'h7f
`define OAG_MASK_MAC 8'h16

// ---------------------------------------------------------------
// literal field widths
// ---------------------------------------------------------------
`define OAG_LIT_MCU_SHORT 5'd5
`define OAG_LIT_MCU_LONG 5'd10
`define OAG_LIT_MOVE_SHORT 5'd8
`define OAG_LIT_MOVE_LONG 5'd16
`define OAG_LIT_BRANCH 5'd16
`define OAG_LIT_DISABLE 5'd14

// ---------------------------------------------------------------
// prefetch post-modify steps allowed for the multiply-accumulate class
// ---------------------------------------------------------------
`define OAG_MAC_STEP_A 16'h0002
`define OAG_MAC_STEP_B 16'h0004
`define OAG_MAC_STEP_C 16'h0006

`endif

// ---- hdl/oag_pkg.sv ----
package oag_pkg;

	// operand addressing modes, one-hot
	typedef enum logic [7:0] {
		OAG_REG_DIRECT = 8'h01,
		OAG_REG_INDIRECT = 8'h02,
		OAG_POST_MOD = 8'h04,
		OAG_PRE_MOD = 8'h08,
		OAG_REG_INDEXED = 8'h10,
		OAG_LIT_OFFSET = 8'h20,
		OAG_LITERAL = 8'h40,
		OAG_FILE_DIRECT = 8'h80
	} oag_mode_type;

	// instruction classes from the decoder, one-hot
	typedef enum logic [8:0] {
		OAG_CL_FILE_REG = 9'h001,
		OAG_CL_MCU = 9'h002,
		OAG_CL_MOVE = 9'h004,
		OAG_CL_ACC = 9'h008,
		OAG_CL_MAC = 9'h010,
		OAG_CL_BRANCH = 9'h020,
		OAG_CL_DISABLE = 9'h040,
		OAG_CL_IMPLIED = 9'h080,
		OAG_CL_NOP = 9'h100
	} oag_class_type;

endpackage

// ---- hdl/oag_ea_if.sv ----
`timescale 1ns/1ps
`default_nettype none

// one effective-address channel between the top and an adder slice
interface oag_ea_if #(parameter int AW = 16);
	oag_pkg::oag_mode_type mode;
	logic [AW-1:0] ptr;
	logic [AW-1:0] base;
	logic [AW-1:0] lit;
	logic [AW-1:0] step;
	logic [AW-1:0] ea;
	logic [AW-1:0] next_ptr;
	logic ptr_we;
	modport calc(input mode, ptr, base, lit, step, output ea, next_ptr, ptr_we);
	modport user(output mode, ptr, base, lit, step, input ea, next_ptr, ptr_we);
endinterface

`default_nettype wire

// ---- hdl/oag_mode_calc.sv ----
`timescale 1ns/1ps
`default_nettype none

// pure combinational address slice; one per channel
module oag_mode_calc #(
	parameter int AW = 16
) (
	oag_ea_if.calc ch
);

	// ---------------------------------------------------------------
	// adders
	// ---------------------------------------------------------------
	// step is signed two's complement, so one adder serves inc and dec
	wire [AW-1:0] stepped = ch.ptr + ch.step;
	wire [AW-1:0] indexed = ch.ptr + ch.base;
	wire [AW-1:0] offset = ch.ptr + ch.lit;

	// ---------------------------------------------------------------
	// address select
	// ---------------------------------------------------------------
	assign ch.ea = (ch.mode == oag_pkg::OAG_PRE_MOD) ? stepped :
		(ch.mode == oag_pkg::OAG_REG_INDEXED) ? indexed :
		(ch.mode == oag_pkg::OAG_LIT_OFFSET) ? offset :
		(ch.mode == oag_pkg::OAG_FILE_DIRECT) ? ch.lit :
		ch.ptr; // indirect and post-modified use the pointer as is

	// pointer is written back only by the two modifying modes
	assign ch.next_ptr = stepped;
	assign ch.ptr_we = (ch.mode == oag_pkg::OAG_POST_MOD) || (ch.mode == oag_pkg::OAG_PRE_MOD);

endmodule

`default_nettype wire

// ---- hdl/oag_top.sv ----
// Overview of operation
// - file-register field addresses lowest 8192 bytes
// - default result goes to W0 or file
// - move reaches the whole data space
// - first three-operand source is register direct
// - second source register, memory or 5-bit literal
// - general modes direct, indirect, post, pre, literal
// - indirect uses pointer unchanged as address
// - post-modify: address then pointer plus step
// - pre-modify: pointer plus step is address
// - indexed address is pointer plus base
// - literal offset address is pointer plus literal
// - move/accumulator add indexed, offset, 8/16 literals
// - move sides differ, share one index field
// - multiply-accumulate pointers only registers eight-eleven
// - eight/nine go X, ten/eleven go Y
// - prefetch indexing only via nine and eleven
// - prefetch modes indirect, post 2/4/6, indexed
// - branch 16-bit signed, disable 14-bit literal
// - implied operands by opcode; no-op none
`timescale 1ns/1ps
`default_nettype none
`include "oag_defines.svh"

module oag_top #(
	parameter int AW = 16
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic req_valid,
	input wire oag_pkg::oag_class_type op_class,
	input wire oag_pkg::oag_mode_type src_mode,
	input wire oag_pkg::oag_mode_type dst_mode,
	input wire logic [3:0] src_ptr_num,
	input wire logic [3:0] dst_ptr_num,
	input wire logic [AW-1:0] src_ptr_value,
	input wire logic [AW-1:0] dst_ptr_value,
	input wire logic [AW-1:0] src_step,
	input wire logic [AW-1:0] dst_step,
	input wire logic [AW-1:0] base_value,
	input wire logic [AW-1:0] literal,
	input wire logic lit_long,
	input wire logic [`OAG_NEAR_BITS-1:0] file_addr,
	input wire logic to_default,
	input wire logic is_multiply,
	input wire oag_pkg::oag_mode_type mac_x_mode,
	input wire logic [3:0] mac_x_num,
	input wire logic [AW-1:0] mac_x_value,
	input wire logic [AW-1:0] mac_x_step,
	input wire oag_pkg::oag_mode_type mac_y_mode,
	input wire logic [3:0] mac_y_num,
	input wire logic [AW-1:0] mac_y_value,
	input wire logic [AW-1:0] mac_y_step,
	output logic out_valid,
	output logic mode_fault,
	output logic near_access,
	output logic [AW-1:0] base_operand,
	output logic [AW-1:0] src_ea,
	output logic src_ptr_we,
	output logic [3:0] src_ptr_id,
	output logic [AW-1:0] src_ptr_next,
	output logic [AW-1:0] dst_ea,
	output logic dst_ptr_we,
	output logic [3:0] dst_ptr_id,
	output logic [AW-1:0] dst_ptr_next,
	output logic x_valid,
	output logic [AW-1:0] x_ea,
	output logic x_ptr_we,
	output logic [3:0] x_ptr_id,
	output logic [AW-1:0] x_ptr_next,
	output logic y_valid,
	output logic [AW-1:0] y_ea,
	output logic y_ptr_we,
	output logic [3:0] y_ptr_id,
	output logic [AW-1:0] y_ptr_next,
	output logic [AW-1:0] operand_literal,
	output logic result_to_default,
	output logic [3:0] dest_reg_id,
	output logic result_pair,
	output logic implied_operand,
	output logic no_operand
);

	// ---------------------------------------------------------------
	// class decode
	// ---------------------------------------------------------------
	wire is_file = (op_class == oag_pkg::OAG_CL_FILE_REG);
	wire is_mcu = (op_class == oag_pkg::OAG_CL_MCU);
	wire is_move = (op_class == oag_pkg::OAG_CL_MOVE);
	wire is_acc = (op_class == oag_pkg::OAG_CL_ACC);
	wire is_mac = (op_class == oag_pkg::OAG_CL_MAC);
	wire is_branch = (op_class == oag_pkg::OAG_CL_BRANCH);
	wire is_disable = (op_class == oag_pkg::OAG_CL_DISABLE);
	wire is_implied = (op_class == oag_pkg::OAG_CL_IMPLIED);
	wire is_nop = (op_class == oag_pkg::OAG_CL_NOP);

	// ---------------------------------------------------------------
	// mode legality per class
	// ---------------------------------------------------------------
	// per-opcode subsets are the decoder's business; here only the class envelope is policed
	wire [7:0] src_mask = is_file ? `OAG_MASK_FILE :
		is_mcu ? `OAG_MASK_MCU :
		is_move ? `OAG_MASK_MOVE :
		is_acc ? `OAG_MASK_ACC : 8'h00;
	wire [7:0] dst_mask = is_mcu ? (`OAG_MASK_MCU & ~8'h40) : // results never land in a literal
		is_move ? (`OAG_MASK_MOVE & ~8'h40) :
		is_acc ? (`OAG_MASK_ACC & ~8'h40) : 8'h00;
	wire uses_src = is_file || is_mcu || is_move || is_acc;
	wire uses_dst = is_mcu || is_move || is_acc;
	wire src_bad = uses_src && ((src_mode & src_mask) == 8'h00);
	wire dst_bad = uses_dst && ((dst_mode & dst_mask) == 8'h00);

	// prefetch pointer checks for the multiply-accumulate class
	function automatic logic mac_bad(input logic [3:0] num, input logic [3:0] lo, input logic [3:0] hi,
		input logic [3:0] idx, input logic [7:0] mode, input logic [AW-1:0] step);
		logic step_ok;
		logic [AW-1:0] mag;
		mag = step[AW-1] ? AW'(-step) : step;
		step_ok = (mag == AW'(`OAG_MAC_STEP_A)) || (mag == AW'(`OAG_MAC_STEP_B)) ||
			(mag == AW'(`OAG_MAC_STEP_C));
		mac_bad = ((num != lo) && (num != hi)) ||
			((mode & `OAG_MASK_MAC) == 8'h00) ||
			((mode == 8'h10) && (num != idx)) ||
			((mode == 8'h04) && !step_ok);
	endfunction

	wire x_bad = is_mac && mac_bad(mac_x_num, `OAG_MAC_X_LO, `OAG_MAC_X_HI, `OAG_MAC_X_INDEX, mac_x_mode, mac_x_step);
	wire y_bad = is_mac && mac_bad(mac_y_num, `OAG_MAC_Y_LO, `OAG_MAC_Y_HI, `OAG_MAC_Y_INDEX, mac_y_mode, mac_y_step);
	wire next_fault = src_bad || dst_bad || x_bad || y_bad;

	// ---------------------------------------------------------------
	// literal field width
	// ---------------------------------------------------------------
	wire [4:0] lit_width = is_mcu ? (lit_long ? `OAG_LIT_MCU_LONG : `OAG_LIT_MCU_SHORT) :
		(is_move || is_acc) ? (lit_long ? `OAG_LIT_MOVE_LONG : `OAG_LIT_MOVE_SHORT) :
		is_disable ? `OAG_LIT_DISABLE : `OAG_LIT_BRANCH;
	wire [AW-1:0] lit_mask = AW'((32'h1 << lit_width) - 32'h1);
	// branch displacement stays full width and is read as signed downstream
	wire [AW-1:0] next_literal = literal & lit_mask;

	// file-direct address: near field for file class, full word for move
	wire [AW-1:0] near_word = AW'(file_addr);
	wire [AW-1:0] direct_word = is_file ? near_word : literal;

	// ---------------------------------------------------------------
	// address channels: 0 source, 1 destination, 2 X prefetch, 3 Y prefetch
	// ---------------------------------------------------------------
	oag_ea_if #(.AW(AW)) ch[4]();
	oag_pkg::oag_mode_type ch_mode [4];
	logic [AW-1:0] ch_ptr [4];
	logic [AW-1:0] ch_lit [4];
	logic [AW-1:0] ch_step [4];
	logic [AW-1:0] ch_ea [4];
	logic [AW-1:0] ch_next [4];
	logic ch_we [4];

	// the single index field feeds both move sides
	assign ch_mode[0] = src_mode;
	assign ch_mode[1] = dst_mode;
	assign ch_mode[2] = mac_x_mode;
	assign ch_mode[3] = mac_y_mode;
	assign ch_ptr[0] = src_ptr_value;
	assign ch_ptr[1] = dst_ptr_value;
	assign ch_ptr[2] = mac_x_value;
	assign ch_ptr[3] = mac_y_value;
	assign ch_lit[0] = (src_mode == oag_pkg::OAG_FILE_DIRECT) ? direct_word : literal;
	assign ch_lit[1] = (dst_mode == oag_pkg::OAG_FILE_DIRECT) ? direct_word : literal;
	assign ch_lit[2] = literal;
	assign ch_lit[3] = literal;
	assign ch_step[0] = src_step;
	assign ch_step[1] = dst_step;
	assign ch_step[2] = mac_x_step;
	assign ch_step[3] = mac_y_step;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_chan
			assign ch[gi].mode = ch_mode[gi];
			assign ch[gi].ptr = ch_ptr[gi];
			assign ch[gi].base = base_value;
			assign ch[gi].lit = ch_lit[gi];
			assign ch[gi].step = ch_step[gi];
			assign ch_ea[gi] = ch[gi].ea;
			assign ch_next[gi] = ch[gi].next_ptr;
			assign ch_we[gi] = ch[gi].ptr_we;
			oag_mode_calc #(.AW(AW)) u_calc (
				.ch(ch[gi])
			);
		end
	endgenerate

	// pointer updates are dropped on a faulted request so state stays intact
	wire go = req_valid && !next_fault;

	// ---------------------------------------------------------------
	// status and operand register
	// ---------------------------------------------------------------
	// one pipeline stage; clock enable low holds every flop
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			out_valid <= 1'b0;
			mode_fault <= 1'b0;
			near_access <= 1'b0;
			base_operand <= '0;
			operand_literal <= '0;
			result_to_default <= 1'b0;
			dest_reg_id <= 4'h0;
			result_pair <= 1'b0;
			implied_operand <= 1'b0;
			no_operand <= 1'b0;
		end else if (clk_en) begin
			out_valid <= req_valid;
			mode_fault <= req_valid && next_fault;
			near_access <= req_valid && is_file;
			base_operand <= base_value;
			operand_literal <= next_literal;
			result_to_default <= is_file && to_default && !is_multiply;
			dest_reg_id <= (is_file && to_default) ? `OAG_DEFAULT_WORK_REG : dst_ptr_num;
			result_pair <= is_file && is_multiply;
			implied_operand <= req_valid && is_implied;
			no_operand <= req_valid && is_nop;
		end
	end

	// ---------------------------------------------------------------
	// source and destination register
	// ---------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			src_ea <= '0;
			src_ptr_we <= 1'b0;
			src_ptr_id <= 4'h0;
			src_ptr_next <= '0;
			dst_ea <= '0;
			dst_ptr_we <= 1'b0;
			dst_ptr_id <= 4'h0;
			dst_ptr_next <= '0;
		end else if (clk_en) begin
			src_ea <= ch_ea[0];
			src_ptr_we <= go && uses_src && ch_we[0];
			src_ptr_id <= src_ptr_num;
			src_ptr_next <= ch_next[0];
			dst_ea <= ch_ea[1];
			dst_ptr_we <= go && uses_dst && ch_we[1];
			dst_ptr_id <= dst_ptr_num;
			dst_ptr_next <= ch_next[1];
		end
	end

	// ---------------------------------------------------------------
	// prefetch register: X side and Y side
	// ---------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			x_valid <= 1'b0;
			x_ea <= '0;
			x_ptr_we <= 1'b0;
			x_ptr_id <= 4'h0;
			x_ptr_next <= '0;
			y_valid <= 1'b0;
			y_ea <= '0;
			y_ptr_we <= 1'b0;
			y_ptr_id <= 4'h0;
			y_ptr_next <= '0;
		end else if (clk_en) begin
			x_valid <= go && is_mac;
			x_ea <= ch_ea[2];
			x_ptr_we <= go && is_mac && ch_we[2];
			x_ptr_id <= mac_x_num;
			x_ptr_next <= ch_next[2];
			y_valid <= go && is_mac;
			y_ea <= ch_ea[3];
			y_ptr_we <= go && is_mac && ch_we[3];
			y_ptr_id <= mac_y_num;
			y_ptr_next <= ch_next[3];
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	wire take = clk_en && req_valid;

	near_field_map_a: assert property (take && is_file && src_mode == oag_pkg::OAG_FILE_DIRECT |=>
		near_access && src_ea == AW'($past(file_addr)) && src_ea < AW'(`OAG_NEAR_BYTES))
		else $error("file address not mapped into near space");

	default_dest_a: assert property (take && is_file && to_default |=> dest_reg_id == `OAG_DEFAULT_WORK_REG)
		else $error("default destination not register zero");

	move_full_a: assert property (take && is_move && src_mode == oag_pkg::OAG_FILE_DIRECT && !next_fault
		|=> src_ea == $past(literal) && !near_access)
		else $error("move direct address not full width");

	base_direct_a: assert property (take && is_mcu |=> base_operand == $past(base_value) && out_valid)
		else $error("base operand not passed directly");

	indirect_plain_a: assert property (take && is_mcu && src_mode == oag_pkg::OAG_REG_INDIRECT
		|=> src_ea == $past(src_ptr_value) && !src_ptr_we)
		else $error("indirect address altered");

	post_mod_a: assert property (take && is_move && src_mode == oag_pkg::OAG_POST_MOD && !next_fault
		|=> src_ea == $past(src_ptr_value) && src_ptr_we && src_ptr_next == $past(src_ptr_value) + $past(src_step))
		else $error("post-modify wrong");

	pre_mod_a: assert property (take && is_mcu && dst_mode == oag_pkg::OAG_PRE_MOD && !next_fault
		|=> dst_ea == dst_ptr_next && dst_ptr_we && dst_ea == $past(dst_ptr_value) + $past(dst_step))
		else $error("pre-modify wrong");

	indexed_sum_a: assert property (take && is_move && src_mode == oag_pkg::OAG_REG_INDEXED
		|=> src_ea == $past(src_ptr_value) + $past(base_value))
		else $error("indexed sum wrong");

	mac_pointer_a: assert property (take && is_mac && (mac_x_num < `OAG_MAC_X_LO || mac_x_num > `OAG_MAC_X_HI)
		|=> mode_fault && !x_valid && !x_ptr_we)
		else $error("illegal prefetch pointer accepted");

	mac_index_a: assert property (take && is_mac && mac_y_mode == oag_pkg::OAG_REG_INDEXED &&
		mac_y_num != `OAG_MAC_Y_INDEX |=> mode_fault && !y_valid)
		else $error("prefetch indexing through wrong register");

	mac_mode_a: assert property (take && is_mac && (mac_x_mode == oag_pkg::OAG_PRE_MOD ||
		mac_x_mode == oag_pkg::OAG_LIT_OFFSET) |=> mode_fault && !x_valid && !x_ptr_we)
		else $error("unsupported prefetch mode accepted");

	disable_lit_a: assert property (take && is_disable |=> operand_literal[AW-1:14] == '0)
		else $error("disable literal wider than field");

endmodule

`default_nettype wire

// ---- test/tb_operand_address_generation.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_operand_address_generation;

	// ---------------------------------------------------------------
	// types and bench state
	// ---------------------------------------------------------------
	// one channel's expected address result; c clear means only a zero write-back is checked
	typedef struct {int c, ea, we, nx, id;} oag_ch_type;
	// one cycle's expected outputs, filled from the inputs at drive time
	typedef struct {int v, b, cf, f, xv, cl, lit, cn, rd, rp, im, no; oag_ch_type src, dst, x, y;} oag_exp_type;

	logic clock, rst_n, clk_en, req_valid, lit_long, to_default, is_multiply;
	oag_pkg::oag_class_type op_class;
	oag_pkg::oag_mode_type src_mode, dst_mode, mac_x_mode, mac_y_mode;
	logic [3:0] src_ptr_num, dst_ptr_num, mac_x_num, mac_y_num;
	logic [15:0] src_ptr_value, dst_ptr_value, src_step, dst_step, base_value, literal;
	logic [15:0] mac_x_value, mac_x_step, mac_y_value, mac_y_step;
	logic [12:0] file_addr;
	logic out_valid, mode_fault, near_access, src_ptr_we, dst_ptr_we, x_valid, x_ptr_we, y_valid, y_ptr_we;
	logic result_to_default, result_pair, implied_operand, no_operand;
	logic [15:0] base_operand, src_ea, src_ptr_next, dst_ea, dst_ptr_next, x_ea, x_ptr_next, y_ea, y_ptr_next;
	logic [15:0] operand_literal;
	logic [3:0] src_ptr_id, dst_ptr_id, x_ptr_id, y_ptr_id, dest_reg_id;
	int errors = 0;
	int checked = 0;
	int seed = 1071;
	oag_exp_type q[$]; // results in flight, one cycle deep
	oag_exp_type last; // what a frozen output should keep showing

	// ---------------------------------------------------------------
	// device under test
	// ---------------------------------------------------------------
	oag_top DUT (.clock, .rst_n, .clk_en, .req_valid, .op_class, .src_mode, .dst_mode, .src_ptr_num,
		.dst_ptr_num, .src_ptr_value, .dst_ptr_value, .src_step, .dst_step, .base_value, .literal,
		.lit_long, .file_addr, .to_default, .is_multiply, .mac_x_mode, .mac_x_num, .mac_x_value,
		.mac_x_step, .mac_y_mode, .mac_y_num, .mac_y_value, .mac_y_step, .out_valid, .mode_fault,
		.near_access, .base_operand, .src_ea, .src_ptr_we, .src_ptr_id, .src_ptr_next, .dst_ea,
		.dst_ptr_we, .dst_ptr_id, .dst_ptr_next, .x_valid, .x_ea, .x_ptr_we, .x_ptr_id, .x_ptr_next,
		.y_valid, .y_ea, .y_ptr_we, .y_ptr_id, .y_ptr_next, .operand_literal, .result_to_default,
		.dest_reg_id, .result_pair, .implied_operand, .no_operand);

	// ---------------------------------------------------------------
	// reference model
	// ---------------------------------------------------------------
	function automatic int rnd(input int n);
		return int'($unsigned($random(seed)) % n);
	endfunction

	// address and pointer update of one channel for a one-hot mode
	function automatic oag_ch_type calc(input int m, p, s, b, l, id);
		calc = '{default: 0};
		calc.c = 1;
		calc.ea = p; // indirect: pointer used as is
		calc.id = id;
		case (m)
			2: ;
			4: begin // post: address first, pointer moves after
				calc.we = 1;
				calc.nx = p + s;
			end
			8: begin // pre: pointer moves, moved value is the address
				calc.ea = p + s;
				calc.we = 1;
				calc.nx = p + s;
			end
			'h10: calc.ea = p + b;
			'h20: calc.ea = p + l;
			'h80: calc.ea = l; // move reaching the whole space
			default: calc.c = 0; // direct and literal carry no address
		endcase
	endfunction

	// prefetch channel legality: own pair, indexing on the high one, steps 2/4/6
	function automatic int macok(input int m, n, s, hi, lo);
		int st;
		st = (s == 2 || s == 4 || s == 6 || s == -2 || s == -4 || s == -6);
		return (n == hi || n == lo) && (m == 2 || (m == 4 && st) || (m == 'h10 && n == hi));
	endfunction

	// ---------------------------------------------------------------
	// compare tasks
	// ---------------------------------------------------------------
	task automatic cmp(input logic [15:0] act, input int exp);
		checked++;
		if (act !== exp[15:0]) begin
			errors++;
			$display("MISMATCH t=%0t act=%h exp=%h", $time, act, exp[15:0]);
		end
	endtask

	// a refused request must never write a pointer back
	task automatic cmp_ch(input logic [15:0] ea, input logic we, input logic [15:0] nx, input logic [3:0] id,
		input oag_ch_type e, input int f);
		if (e.c) begin
			cmp(we, f ? 0 : e.we);
			if (!f) begin
				cmp(ea, e.ea);
				if (e.we) cmp(nx, e.nx);
				cmp(id, e.id);
			end
		end else begin
			cmp(we, 0);
		end
	endtask

	task automatic check(input oag_exp_type e);
		cmp(out_valid, e.v);
		if (e.v) begin
			cmp(base_operand, e.b);
			if (e.cf) cmp(mode_fault, e.f);
			cmp_ch(src_ea, src_ptr_we, src_ptr_next, src_ptr_id, e.src, e.f);
			cmp_ch(dst_ea, dst_ptr_we, dst_ptr_next, dst_ptr_id, e.dst, e.f);
			cmp_ch(x_ea, x_ptr_we, x_ptr_next, x_ptr_id, e.x, e.f);
			cmp_ch(y_ea, y_ptr_we, y_ptr_next, y_ptr_id, e.y, e.f);
			cmp(x_valid, e.xv);
			cmp(y_valid, e.xv);
			if (e.cl) cmp(operand_literal, e.lit);
			if (e.cn) begin
				cmp(near_access, 1);
				cmp(result_to_default, e.rd);
				cmp(result_pair, e.rp);
				if (e.rd) cmp(dest_reg_id, 0);
			end else begin
				cmp(near_access, 0);
				cmp(result_to_default, 0);
				cmp(result_pair, 0);
			end
			cmp(implied_operand, e.im);
			cmp(no_operand, e.no);
		end else begin
			cmp(src_ptr_we, 0);
			cmp(dst_ptr_we, 0);
			cmp(x_valid, 0);
			cmp(y_valid, 0);
			cmp(mode_fault, 0);
			cmp(implied_operand, 0);
			cmp(no_operand, 0);
		end
	endtask

	// ---------------------------------------------------------------
	// stimulus: random request, expectation pushed beside it
	// ---------------------------------------------------------------
	task automatic issue(input int en, input int req);
		oag_exp_type e;
		int steps[7] = '{2, 4, 6, -2, -4, -6, 3};
		int c, sm, dm, sp, dp, ss, ds, bv, lt, lg, sn, dn, td, mu;
		int xm, ym, xn, yn, xp, yp, xs, ys, msk;
		c = rnd(9);
		sm = 1 << rnd(8);
		dm = 1 << rnd(6); // literal and file-direct never name a destination
		sp = rnd(65536);
		dp = rnd(65536);
		ss = rnd(16) - 8;
		ds = rnd(16) - 8;
		bv = rnd(65536);
		lt = rnd(65536);
		lg = rnd(2);
		sn = rnd(16);
		dn = rnd(16);
		td = rnd(2);
		mu = rnd(2);
		xm = 1 << (rnd(5) + 1); // indirect, post, pre, indexed, literal offset
		ym = 1 << (rnd(5) + 1);
		xn = 7 + rnd(3); // one number outside the x pair
		yn = 10 + rnd(3); // one number outside the y pair
		xp = rnd(65536);
		yp = rnd(65536);
		xs = steps[rnd(7)];
		ys = steps[rnd(7)];
		if (c == 4) begin // prefetch class keeps its main modes inside its envelope
			sm = 2;
			dm = 2;
		end
		if (c == 0) begin
			sm = 'h80;
			dm = 'h80;
		end
		clk_en <= en[0];
		req_valid <= req[0];
		op_class <= oag_pkg::oag_class_type'(9'h001 << c);
		src_mode <= oag_pkg::oag_mode_type'(sm[7:0]);
		dst_mode <= oag_pkg::oag_mode_type'(dm[7:0]);
		mac_x_mode <= oag_pkg::oag_mode_type'(xm[7:0]);
		mac_y_mode <= oag_pkg::oag_mode_type'(ym[7:0]);
		src_ptr_num <= sn[3:0];
		dst_ptr_num <= dn[3:0];
		mac_x_num <= xn[3:0];
		mac_y_num <= yn[3:0];
		src_ptr_value <= sp[15:0];
		dst_ptr_value <= dp[15:0];
		src_step <= ss[15:0];
		dst_step <= ds[15:0];
		base_value <= bv[15:0];
		literal <= lt[15:0];
		lit_long <= lg[0];
		file_addr <= lt[12:0];
		to_default <= td[0];
		is_multiply <= mu[0];
		mac_x_value <= xp[15:0];
		mac_y_value <= yp[15:0];
		mac_x_step <= xs[15:0];
		mac_y_step <= ys[15:0];
		if (!en) begin // frozen edge: outputs keep the last result
			q.push_back(last);
			return;
		end
		e.v = req;
		e.b = bv;
		e.im = (c == 7);
		e.no = (c == 8);
		case (c)
			0: begin
				e.src = calc(sm, sp, ss, bv, lt & 'h1fff, sn); // near field lands in the lowest bytes
				e.cn = 1;
				e.cf = 1;
				e.rd = td && !mu;
				e.rp = mu;
			end
			1, 2, 3: begin
				msk = (c == 1) ? 'h4f : (c == 2) ? 'hff : 'h7f;
				e.cf = 1;
				e.f = !(sm & msk) || !(dm & msk & 'hbf);
				e.src = calc(sm, sp, ss, bv, lt, sn);
				e.dst = calc(dm, dp, ds, bv, lt, dn);
				if (sm == 'h40 && !e.f) begin
					e.cl = 1;
					e.lit = lt & ((c == 1) ? (lg ? 'h3ff : 'h1f) : (lg ? 'hffff : 'hff));
				end
			end
			4: begin
				e.cf = 1;
				e.x = calc(xm, xp, xs, bv, 0, xn);
				e.y = calc(ym, yp, ys, bv, 0, yn);
				e.f = !(macok(xm, xn, xs, 9, 8) && macok(ym, yn, ys, 11, 10));
				e.xv = !e.f;
			end
			5: begin // branch target passes whole and signed
				e.cl = 1;
				e.lit = lt;
			end
			6: begin
				e.cl = 1;
				e.lit = lt & 'h3fff;
			end
			default: ;
		endcase
		if (!req) e = '{v: 0, default: 0};
		q.push_back(e);
		last = e;
	endtask

	// ---------------------------------------------------------------
	// closing
	// ---------------------------------------------------------------
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ---------------------------------------------------------------
	// clock, watchdog, main sequence
	// ---------------------------------------------------------------
	initial begin
		clock = 0;
		forever #50 clock = ~clock;
	end

	// about 610 cycles are needed; three times that is a hang
	initial begin
		#200000;
		errors++;
		finish_test();
	end

	initial begin
		rst_n = 0;
		clk_en = 1;
		req_valid = 0;
		op_class = oag_pkg::OAG_CL_NOP;
		src_mode = oag_pkg::OAG_REG_DIRECT;
		dst_mode = oag_pkg::OAG_REG_DIRECT;
		mac_x_mode = oag_pkg::OAG_REG_DIRECT;
		mac_y_mode = oag_pkg::OAG_REG_DIRECT;
		{src_ptr_num, dst_ptr_num, mac_x_num, mac_y_num} = '0;
		{src_ptr_value, dst_ptr_value, src_step, dst_step, base_value, literal} = '0;
		{mac_x_value, mac_x_step, mac_y_value, mac_y_step} = '0;
		{lit_long, file_addr, to_default, is_multiply} = '0;
		repeat (5) @(posedge clock);
		rst_n <= 1;
		@(negedge clock);
		cmp(out_valid, 0); // outputs clear in reset
		cmp(mode_fault, 0);
		// back-to-back requests, with gaps and frozen edges mixed in
		for (int i = 0; i < 600; i++) begin
			@(posedge clock);
			issue(rnd(8) != 0, rnd(6) != 0);
			@(negedge clock);
			if (q.size() > 1) check(q.pop_front());
		end
		finish_test();
	end

endmodule

`default_nettype wire
